// ---- hdl/rbx_core.sv ----
// How it works
// RQ1 - top bits 11010 mean jump, 11-bit offset
// RQ2 - signed offset doubled, added to counter
// RQ3 - target is own address plus two plus offset
// RQ4 - jump takes two cycles, second is no-op
// RQ5 - nibble 1000 sets indexed bit in file
// RQ6 - access bit zero selects shared bank
// RQ7 - access bit one uses bank pointer
// RQ8 - extended set, f up to 95 is indexed
// RQ9 - no status flag is ever changed
// RQ10 - bit set reads Q2, modifies Q3, writes Q4
`timescale 1ns/1ns
`default_nettype none
module rbx_core
  import rbx_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            resetn,
  input  wire logic [15:0]     fetch_word,     // word at fetch_addr
  input  wire logic [3:0]      bank_pointer,   // current bank select
  input  wire logic            ext_set_en,     // extended instruction set on
  input  wire logic [DA_W-1:0] index_base,     // base for indexed literal mode
  input  wire logic [7:0]      data_rdata,     // file register read data
  output logic      [PC_W-1:0] fetch_addr,     // program counter
  output logic      [1:0]      q_phase,        // current instruction phase
  output logic      [DA_W-1:0] data_addr,      // file register address
  output logic                 data_rd,        // read strobe, Q2
  output logic                 data_wr,        // write strobe, Q4
  output logic      [7:0]      data_wdata,     // modified byte
  output logic                 status_wr       // status flag write enable
);
  // state of the four-phase sequencer and of the data path
  rbx_phase_type    phase;                     // four-phase cycle position
  logic [PC_W-1:0]  pc;                        // already incremented counter
  logic [15:0]      ir;                        // instruction in execution
  logic             flush;                     // second jump cycle
  logic [7:0]       rd_latch;                  // byte read in Q2
  logic [7:0]       mod_byte;                  // byte modified in Q3
  logic [DA_W-1:0]  addr_hold;                 // address kept for the cycle

  // decode, a flushed cycle decodes nothing; the flush term stays even though
  // the flushed word is a no-op, so a stale word can never run
  wire logic is_jump   = !flush && (ir[15:11] == OPC_JUMP);    // RQ1
  wire logic is_bitset = !flush && (ir[15:12] == OPC_BITSET);  // RQ5
  // sign extend and double the offset
  // the low bit is always zero: jumps land on word boundaries
  wire logic [PC_W-1:0] jump_ofs =
    {{(PC_W-OFS_W-1){ir[OFS_W-1]}}, ir[OFS_W-1:0], 1'b0};      // RQ2
  // pc is own address plus two here, so the sum is the target
  wire logic [PC_W-1:0] jump_target = pc + jump_ofs;           // RQ3
  // without a jump the counter steps one word
  wire logic [PC_W-1:0] next_pc = is_jump ? jump_target : pc + PC_STEP;

  // outputs of the bit-set address and byte former
  wire logic [DA_W-1:0] bs_addr;
  wire logic [7:0]      bs_wdata;
  wire logic            bs_indexed;

  // address and byte forming live apart, so the bank rules sit in one place
  rbx_bitset rbx_bitset_i (
    .instr        (ir),
    .bank_pointer (bank_pointer),
    .ext_set_en   (ext_set_en),
    .index_base   (index_base),
    .rd_data      (rd_latch),
    .addr         (bs_addr),
    .wr_data      (bs_wdata),
    .indexed      (bs_indexed)
  );

  // phase counter, wraps every four clocks; the enum has exactly four codes,
  // so the wrap needs no compare and no illegal state can be reached
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      phase <= Q1;
    end else begin
      phase <= rbx_phase_type'(phase + 2'h1);
    end
  end

  // program counter and instruction register change only in Q4
  // counter and word move together, so outside a jump the prefetched word
  // belongs to the address that the counter has just left; a jump loads a no-op
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pc    <= PC_RST;
      ir    <= NOP_WORD;
      flush <= 1'b0;
    end else if (phase == Q4) begin
      // a jump cannot sit in the flushed slot, that slot holds a no-op
      pc    <= next_pc;                                        // RQ4
      // the word fetched behind a jump is thrown away
      ir    <= is_jump ? NOP_WORD : fetch_word;                // RQ4
      flush <= is_jump;                                        // RQ4
    end
  end

  // read-modify-write of the file register
  // the address is frozen at the end of Q1, so a later change of bank or mode
  // cannot split one read-modify-write over two registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_latch  <= 8'h00;
      mod_byte  <= 8'h00;
      addr_hold <= '0;
    end else begin
      if (phase == Q1) begin
        addr_hold <= bs_addr;                                  // RQ10
      end
      // a byte seen outside a bit set is ignored, the bus shows junk then
      if (phase == Q2 && is_bitset) begin
        rd_latch <= data_rdata;                                // RQ10
      end
      // Q3 merges the set bit into the byte read in Q2
      if (phase == Q3) begin
        mod_byte <= bs_wdata;                                  // RQ10
      end
    end
  end

  // data outputs come straight from flip-flops, strobes from registered terms
  assign fetch_addr = pc;
  assign q_phase    = phase;
  assign data_addr  = addr_hold;
  assign data_rd    = is_bitset && (phase == Q2);              // RQ10
  assign data_wr    = is_bitset && (phase == Q4);              // RQ10
  assign data_wdata = mod_byte;
  // neither instruction touches the status flags
  assign status_wr  = 1'b0;                                    // RQ9

  // every check sleeps through reset and runs on the core clock; there is
  // one domain only, so one default clocking serves them all
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // a jump executes in the Q4 that writes the counter
  sequence jump_exec_s;
    phase == Q4 && is_jump;
  endsequence
  // the whole following cycle is the flushed slot
  sequence flush_cycle_s;
    flush [*4];
  endsequence
  // read in Q2, nothing in Q3, write back in Q4
  sequence rmw_steps_s;
    data_rd ##1 (!data_rd && !data_wr) ##1 data_wr;
  endsequence

  // jump: recognition, target arithmetic and the flushed second cycle
  jump_decode_a: assert property ( // RQ1
    phase == Q4 && !flush && ir[15:11] == 5'h1A |=> flush)
    else $error("jump not recognised");
  jump_target_a: assert property ( // RQ3
    jump_exec_s |=> fetch_addr ==
      $past(fetch_addr) + {{9{$past(ir[10])}}, $past(ir[10:0]), 1'b0})
    else $error("jump target wrong");
  jump_sign_a: assert property ( // RQ2
    phase == Q4 && is_jump && ir[10:0] == 11'h400
    |=> fetch_addr == $past(fetch_addr) - 21'h000800)
    else $error("negative offset wrong");
  jump_max_a: assert property ( // RQ2
    phase == Q4 && is_jump && ir[10:0] == 11'h3FF
    |=> fetch_addr == $past(fetch_addr) + 21'h0007FE)
    else $error("positive offset wrong");
  // the word fetched behind a jump must never execute
  jump_flush_a: assert property (jump_exec_s |=> flush_cycle_s ##1 !flush) // RQ4
    else $error("jump second cycle not a no-op");
  flush_nop_a: assert property (jump_exec_s |=> ir == NOP_WORD) // RQ4
    else $error("word behind jump not dropped");
  flush_quiet_a: assert property (flush |-> !data_rd && !data_wr) // RQ4
    else $error("flushed cycle did work");

  // counter moves only at the end of Q4, by one word when no jump runs;
  // a move elsewhere would tear the fetch of the next word
  pc_hold_a: assert property (phase != Q4 |=> $stable(fetch_addr)) // RQ4
    else $error("counter moved outside Q4");
  pc_step_a: assert property ( // RQ3
    phase == Q4 && !is_jump |=> fetch_addr == $past(fetch_addr) + 21'h000002)
    else $error("counter step wrong");
  fetch_take_a: assert property ( // RQ4
    phase == Q4 && !is_jump |=> ir == $past(fetch_word))
    else $error("fetched word not taken");

  // bit set: the read-modify-write steps and the byte written back
  rmw_order_a: assert property ( // RQ10
    phase == Q1 && !flush && ir[15:12] == 4'h8 |=> rmw_steps_s)
    else $error("bit set steps out of order");
  bit_rmw_a: assert property ( // RQ10
    data_rd |-> ##2 data_wr && data_wdata[$past(ir[11:9], 2)] == 1'b1)
    else $error("bit not set on write back");
  // only the chosen bit may differ from the byte read in Q2
  bit_keep_a: assert property ( // RQ5
    data_rd |-> ##2 (data_wdata | (8'h01 << ir[11:9])) ==
    ($past(data_rdata, 2) | (8'h01 << ir[11:9])))
    else $error("other bits changed");
  // read and write must reach the same register
  addr_steady_a: assert property (data_rd |=> $stable(data_addr) [*2]) // RQ10
    else $error("file address moved during bit set");

  // data address forming for the three addressing cases
  bank_addr_a: assert property ( // RQ7
    data_wr && ir[8] |-> data_addr == {bank_pointer, ir[7:0]})
    else $error("bank address wrong");
  access_addr_a: assert property ( // RQ6
    data_wr && !ir[8] && !ext_set_en && ir[7:0] < 8'h60 |-> data_addr == {4'h0, ir[7:0]})
    else $error("shared bank address wrong");
  high_access_a: assert property ( // RQ6
    data_wr && !ir[8] && ir[7:0] >= 8'h60 |-> data_addr == {4'hF, ir[7:0]})
    else $error("upper shared bank address wrong");
  index_addr_a: assert property ( // RQ8
    data_wr && !ir[8] && ext_set_en && ir[7:0] <= 8'h5F
    |-> data_addr == index_base + {4'h0, ir[7:0]})
    else $error("indexed address wrong");
  // the mode flag must agree with the three conditions for indexed mode
  index_flag_a: assert property ( // RQ8
    data_wr |-> bs_indexed == (!ir[8] && ext_set_en && ir[7:0] <= 8'h5F))
    else $error("indexed mode flag wrong");

  // status flags stay out of reach of both instructions
  status_quiet_a: assert property (status_wr == 1'b0) // RQ9
    else $error("status written");
endmodule : rbx_core
`default_nettype wire

// ---- hdl/rbx_bitset.sv ----
`timescale 1ns/1ns
`default_nettype none
package rbx_pkg;
  localparam int          PC_W        = 21;        // program counter width
  localparam int          DA_W        = 12;        // data address width
  localparam logic [4:0]  OPC_JUMP    = 5'h1A;     // top five bits of the jump
  localparam logic [3:0]  OPC_BITSET  = 4'h8;      // top nibble of the bit set
  localparam int          OFS_W       = 11;        // jump offset field width
  localparam int          BIT_LSB     = 9;         // bit index field position
  localparam int          ACC_BIT     = 8;         // bank-access bit position
  localparam logic [7:0]  ACC_SPLIT   = 8'h60;     // low/high split of access bank
  localparam logic [7:0]  IDX_LIMIT   = 8'h5F;     // top of indexed literal window
  localparam logic [3:0]  ACC_LO_BANK = 4'h0;      // shared low bank
  localparam logic [3:0]  ACC_HI_BANK = 4'hF;      // shared high bank
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002; // one word in bytes
  localparam logic [PC_W-1:0] PC_RST  = 21'h000000; // reset vector
  localparam logic [15:0] NOP_WORD    = 16'h0000;  // word used to flush
  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} rbx_phase_type;
endpackage : rbx_pkg

// address former and bit modifier for the bit-set instruction
module rbx_bitset
  import rbx_pkg::*;
(
  input  wire logic [15:0]     instr,
  input  wire logic [3:0]      bank_pointer,
  input  wire logic            ext_set_en,
  input  wire logic [DA_W-1:0] index_base,
  input  wire logic [7:0]      rd_data,
  output logic      [DA_W-1:0] addr,
  output logic      [7:0]      wr_data,
  output logic                 indexed
);
  wire logic [7:0] file_f   = instr[7:0];           // file address field
  wire logic       use_bank = instr[ACC_BIT];       // bank-access bit
  wire logic [2:0] bit_sel  = instr[BIT_LSB+2:BIT_LSB]; // bit index
  // indexed mode only when access bit clear, extension on, f in window
  assign indexed = !use_bank && ext_set_en && (file_f <= IDX_LIMIT); // RQ8
  wire logic [DA_W-1:0] bank_addr = {bank_pointer, file_f};          // RQ7
  // shared bank: low part of f maps low, upper part maps to the top bank
  wire logic [DA_W-1:0] acc_addr  =
    (file_f < ACC_SPLIT) ? {ACC_LO_BANK, file_f} : {ACC_HI_BANK, file_f}; // RQ6
  wire logic [DA_W-1:0] idx_addr  = index_base + {4'h0, file_f};      // RQ8
  assign addr = use_bank ? bank_addr : (indexed ? idx_addr : acc_addr);
  assign wr_data = rd_data | (8'h01 << bit_sel);                      // RQ5
endmodule : rbx_bitset
`default_nettype wire

// ---- dv/rbx_mem.sv ----
`timescale 1ns/1ns
`default_nettype none
// far side: program words and the data file
module rbx_mem
  import rbx_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic [PC_W-1:0] fetch_addr,
  output logic      [15:0]     fetch_word,
  input  wire logic [DA_W-1:0] data_addr,
  input  wire logic            data_rd,
  input  wire logic            data_wr,
  input  wire logic [7:0]      data_wdata,
  output logic      [7:0]      data_rdata
);
  logic [15:0] prog [0:127];  // small store, upper address bits alias
  logic [7:0]  dmem [0:4095]; // full data space
  assign fetch_word = prog[fetch_addr[7:1]];
  // outside the read strobe the bus shows the inverse, never a stale byte
  assign data_rdata = data_rd ? dmem[data_addr] : ~dmem[data_addr];
  // write back lands at the end of the write clock
  always @(posedge core_clk) begin
    if (data_wr) dmem[data_addr] <= data_wdata;
  end
endmodule : rbx_mem
`default_nettype wire

// ---- dv/rbx_core_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module rbx_core_tb_top;
  import rbx_pkg::*;
  logic core_clk = 1'b0, resetn = 1'b0, ext_set_en = 1'b0;
  logic [3:0] bank_pointer = 4'h0;
  logic [DA_W-1:0] index_base = 12'h200; // indexed mode base
  logic [15:0] fetch_word;
  logic [7:0] data_rdata, data_wdata;
  logic [PC_W-1:0] fetch_addr;
  logic [1:0] q_phase;
  logic [DA_W-1:0] data_addr;
  logic data_rd, data_wr, status_wr;
  int n_mismatch = 0, checks_done = 0;
  rbx_core rbx_core_i (.core_clk(core_clk), .resetn(resetn), .fetch_word(fetch_word),
    .bank_pointer(bank_pointer), .ext_set_en(ext_set_en), .index_base(index_base),
    .data_rdata(data_rdata), .fetch_addr(fetch_addr), .q_phase(q_phase),
    .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr),
    .data_wdata(data_wdata), .status_wr(status_wr));
  rbx_mem rbx_mem_i (.core_clk(core_clk), .fetch_addr(fetch_addr), .fetch_word(fetch_word),
    .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rdata(data_rdata));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // compare one value, counting every call
  task automatic chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // compare one byte, counting every call
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  // compare one flag, counting every call
  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_flag
  // status flags must never be written, watched on every clock out of reset
  always @(posedge core_clk) begin
    if (resetn) chk_flag(status_wr, 1'b0);
  end
  // fill both stores, program with no-ops and data with 0A, then a fresh reset of 5 clocks
  task automatic restart();
    for (int i = 0; i < 128; i++) rbx_mem_i.prog[i] = NOP_WORD;
    for (int i = 0; i < 4096; i++) rbx_mem_i.dmem[i] = 8'h0A;
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
  endtask : restart
  // jump at 0, a bit set behind it must be flushed
  task automatic t_jump(input logic [10:0] n);
    logic [PC_W-1:0] tgt;
    restart();
    rbx_mem_i.prog[0] = {OPC_JUMP, n};
    rbx_mem_i.prog[1] = 16'h8010;
    tgt = PC_STEP + {{9{n[10]}}, n, 1'b0};
    repeat (8) @(posedge core_clk);
    #1 chk(fetch_addr, tgt);
    chk_byte({6'h00, q_phase}, 8'h00);
    repeat (4) @(posedge core_clk);
    #1 chk(fetch_addr, tgt + PC_STEP);
    chk_byte(rbx_mem_i.dmem[12'h010], 8'h0A);
    $display("jump test %h done", n);
  endtask : t_jump
  // one bit set, judged by the byte at the expected address
  task automatic t_set(input logic ext, input logic a, input logic [7:0] f,
                       input logic [2:0] b, input logic [3:0] bp, input logic [11:0] ea);
    restart();
    ext_set_en <= ext;
    bank_pointer <= bp;
    rbx_mem_i.prog[0] = {OPC_BITSET, b, a, f};
    repeat (8) @(posedge core_clk);
    #1 chk_byte(rbx_mem_i.dmem[ea], 8'h0A | (8'h01 << b));
    chk_byte(data_wdata, 8'h0A | (8'h01 << b));
    $display("bit set test %h done", ea);
  endtask : t_set
  // verdict, the only place the run ends
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    t_jump(11'h3FF);
    t_jump(11'h400);
    t_jump(11'h005);
    t_set(1'b0, 1'b1, 8'h25, 3'h7, 4'h3, 12'h325);
    t_set(1'b0, 1'b0, 8'h25, 3'h2, 4'h3, 12'h025);
    t_set(1'b0, 1'b0, 8'hA0, 3'h0, 4'h3, 12'hFA0);
    t_set(1'b1, 1'b0, 8'h5F, 3'h3, 4'h3, 12'h25F);
    t_set(1'b1, 1'b0, 8'h60, 3'h4, 4'h3, 12'hF60);
    t_set(1'b1, 1'b1, 8'h10, 3'h1, 4'h5, 12'h510);
    conclude();
  end
endmodule : rbx_core_tb_top
`default_nettype wire
